// [rtl/adc_seq_pkg.sv]
// constants shared by the converter sequencer files
package adc_seq_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int clk_mhz = 125;
  localparam int wake_pulse_ns = 1000;
  localparam int convert_ns = 4500;
  // least times round up
  localparam int wake_pulse_cycles = (wake_pulse_ns * clk_mhz + 999) / 1000;
  localparam int convert_cycles = (convert_ns * clk_mhz + 999) / 1000;
  localparam int result_width = 8;
  localparam int cnt_width = 16;
  localparam logic [result_width-1:0] result_reset = 8'h00;
  localparam logic [result_width-1:0] sar_top_bit = 8'h80;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    st_powered_down,
    st_waking,
    st_tracking,
    st_converting
  } seq_state_t;
endpackage : adc_seq_pkg

// [rtl/adc_sar_engine.sv]
// successive approximation engine resolving one bit per step
`timescale 1ns/1ps
module adc_sar_engine #(
  parameter int width = 8
) (
  // clock and control
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire logic step_in,
  // digitised sample of the held input: a trial bit is kept when the sample is at or above the trial level
  input wire logic [width-1:0] sample_in,
  // result
  output logic [width-1:0] code_out,
  output logic done_out
);
  logic [width-1:0] code_r;
  logic [width-1:0] code_nxt;
  logic [width-1:0] bit_r;
  logic [width-1:0] bit_nxt;
  logic done_r;
  logic done_nxt;

  // ****************************************
  // next values
  // ****************************************
  always_comb
  begin
    code_nxt = code_r;
    bit_nxt = bit_r;
    done_nxt = done_r;
    if (start_in)
    begin
      code_nxt = '0;
      bit_nxt = {1'b1, {(width-1){1'b0}}};
      done_nxt = 1'b0;
    end
    else if (step_in && bit_r != '0)
    begin
      if (sample_in >= (code_r | bit_r))
        code_nxt = code_r | bit_r;
      bit_nxt = bit_r >> 1;
      if (bit_r[0])
        done_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      code_r <= '0;
      bit_r <= '0;
      done_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      code_r <= code_nxt;
      bit_r <= bit_nxt;
      done_r <= done_nxt;
    end
  end

  assign code_out = code_r;
  assign done_out = done_r;
endmodule : adc_sar_engine

// [rtl/adc_convert_power_sequencer.sv]
// convert-start, power and busy sequencer of an 8-bit sampling converter
`timescale 1ns/1ps
module adc_convert_power_sequencer #(
  parameter int wake_cycles = adc_seq_pkg::wake_pulse_cycles,
  parameter int conv_cycles = adc_seq_pkg::convert_cycles,
  parameter int width = adc_seq_pkg::result_width
) (
  // clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // host control pins
  input wire logic convert_start_n_in,
  input wire logic chip_select_n_in,
  input wire logic read_n_in,
  // analog front end, digitised sample of held input (0 to reference)
  input wire logic [width-1:0] sample_in,
  // status and power
  output logic busy_out,
  output logic powered_out,
  output logic hold_out,
  output logic auto_power_down_out,
  // three-state result bus
  output logic [width-1:0] result_bus_out,
  output logic result_bus_oe_out
);
  // ****************************************
  // state
  // ****************************************
  adc_seq_pkg::seq_state_t state_r;
  adc_seq_pkg::seq_state_t state_nxt;
  logic [adc_seq_pkg::cnt_width-1:0] wake_cnt_r;
  logic [adc_seq_pkg::cnt_width-1:0] wake_cnt_nxt;
  logic [adc_seq_pkg::cnt_width-1:0] conv_cnt_r;
  logic [adc_seq_pkg::cnt_width-1:0] conv_cnt_nxt;
  logic start_n_r;
  logic gated_r;
  logic gated_nxt;
  logic wake_pulse_r;
  logic wake_pulse_nxt;
  logic busy_r;
  logic busy_nxt;
  logic powered_r;
  logic powered_nxt;
  logic hold_r;
  logic hold_nxt;
  logic auto_pd_r;
  logic auto_pd_nxt;
  logic [width-1:0] result_r;
  logic [width-1:0] result_nxt;
  logic [width-1:0] bus_r;
  logic [width-1:0] bus_nxt;
  logic bus_oe_r;
  logic bus_oe_nxt;
  logic start_rise;
  logic gated_fall;
  logic sar_start;
  logic sar_step;
  logic sar_done;
  logic [width-1:0] sar_code;

  // pin is synchronous to the clock, so a single register finds edges
  assign start_rise = convert_start_n_in && !start_n_r;

  // ****************************************
  // successive approximation engine
  // ****************************************
  adc_sar_engine #(
    .width(width)
  ) u_sar (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .start_in(sar_start),
    .step_in(sar_step),
    .sample_in(sample_in),
    .code_out(sar_code),
    .done_out(sar_done)
  );

  // ****************************************
  // count decode
  // ****************************************
  // true on the last cycle of an n-cycle span counted from zero
  function automatic logic at_last(
    input logic [adc_seq_pkg::cnt_width-1:0] cnt,
    input int n
  );
    return cnt == adc_seq_pkg::cnt_width'(n - 1);
  endfunction : at_last

  // ****************************************
  // wake pulse and gated start
  // ****************************************
  always_comb
  begin
    wake_cnt_nxt = wake_cnt_r;
    wake_pulse_nxt = wake_pulse_r;
    // rising edge wakes
    // edges while busy are ignored so a conversion is never cut short
    if (start_rise && !busy_r)
    begin
      wake_pulse_nxt = 1'b1;
      wake_cnt_nxt = '0;
    end
    else if (wake_pulse_r)
    begin
      if (at_last(wake_cnt_r, wake_cycles))
        wake_pulse_nxt = 1'b0;
      else
        wake_cnt_nxt = wake_cnt_r + 1'b1;
    end
    // gated start as OR
    // pin high or pulse high keeps it up: the later fall starts converting
    gated_nxt = convert_start_n_in || wake_pulse_nxt;
    gated_fall = gated_r && !gated_nxt;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      wake_cnt_r <= '0;
      // start is held low at power-on, so no edge is seen after reset
      start_n_r <= 1'b0;
      gated_r <= 1'b0;
      wake_pulse_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      wake_cnt_r <= wake_cnt_nxt;
      start_n_r <= convert_start_n_in;
      gated_r <= gated_nxt;
      wake_pulse_r <= wake_pulse_nxt;
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    conv_cnt_nxt = conv_cnt_r;
    busy_nxt = busy_r;
    powered_nxt = powered_r;
    hold_nxt = hold_r;
    auto_pd_nxt = auto_pd_r;
    result_nxt = result_r;
    sar_start = 1'b0;
    sar_step = 1'b0;
    if (start_rise && !busy_r)
      powered_nxt = 1'b1;
    unique case (state_r)
      adc_seq_pkg::st_powered_down:
      begin
        if (start_rise)
          state_nxt = adc_seq_pkg::st_waking;
      end
      adc_seq_pkg::st_waking, adc_seq_pkg::st_tracking:
      begin
        if (gated_fall && powered_nxt)
        begin
          state_nxt = adc_seq_pkg::st_converting;
          busy_nxt = 1'b1;
          hold_nxt = 1'b1;
          conv_cnt_nxt = '0;
          sar_start = 1'b1;
        end
      end
      adc_seq_pkg::st_converting:
      begin
        // one bit per step
        // the last bit settles a cycle before the end, in time to latch
        sar_step = !at_last(conv_cnt_r, conv_cycles) &&
          conv_cnt_r >= adc_seq_pkg::cnt_width'(conv_cycles - width - 1);
        if (at_last(conv_cnt_r, conv_cycles))
        begin
          busy_nxt = 1'b0;
          hold_nxt = 1'b0;
          result_nxt = sar_done ? sar_code : result_r;
          if (convert_start_n_in)
          begin
            auto_pd_nxt = 1'b0;
            state_nxt = adc_seq_pkg::st_tracking;
          end
          else
          begin
            auto_pd_nxt = 1'b1;
            powered_nxt = 1'b0;
            state_nxt = adc_seq_pkg::st_powered_down;
          end
        end
        else
          conv_cnt_nxt = conv_cnt_r + 1'b1;
      end
      default:
        state_nxt = adc_seq_pkg::st_powered_down;
    endcase
    // woken again from tracking before next conversion
    if (state_r == adc_seq_pkg::st_tracking && start_rise)
      state_nxt = adc_seq_pkg::st_waking;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state_r <= adc_seq_pkg::st_powered_down;
      conv_cnt_r <= '0;
      busy_r <= 1'b0;
      powered_r <= 1'b0;
      hold_r <= 1'b0;
      auto_pd_r <= 1'b1;
      result_r <= adc_seq_pkg::result_reset;
    end
    else if (clk_en_in)
    begin
      state_r <= state_nxt;
      conv_cnt_r <= conv_cnt_nxt;
      busy_r <= busy_nxt;
      powered_r <= powered_nxt;
      hold_r <= hold_nxt;
      auto_pd_r <= auto_pd_nxt;
      result_r <= result_nxt;
    end
  end

  // ****************************************
  // result bus
  // ****************************************
  always_comb
  begin
    bus_oe_nxt = !chip_select_n_in && !read_n_in;
    bus_nxt = bus_oe_nxt ? result_nxt : bus_r;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      bus_r <= adc_seq_pkg::result_reset;
      bus_oe_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      bus_r <= bus_nxt;
      bus_oe_r <= bus_oe_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign busy_out = busy_r;
  assign powered_out = powered_r;
  assign hold_out = hold_r;
  assign auto_power_down_out = auto_pd_r;
  assign result_bus_out = bus_r;
  assign result_bus_oe_out = bus_oe_r;
endmodule : adc_convert_power_sequencer

// [dv/host_model.sv]
// host model driving the convert-start pin
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic ref_clk_in,
  // convert start
  output logic convert_start_n_out
);
  initial convert_start_n_out = 1'b0;
  task automatic start_level(input logic lvl);
    @(negedge ref_clk_in);
    convert_start_n_out = lvl;
  endtask : start_level
  task automatic start_pulse(input int hi);
    start_level(1'b1);
    repeat (hi) @(negedge ref_clk_in);
    convert_start_n_out = 1'b0;
  endtask : start_pulse
endmodule : host_model

// [dv/adc_seq_chk.sv]
// port assertions of the converter sequencer
`timescale 1ns/1ps
module adc_seq_chk #(
  parameter int wake_cycles = 4,
  parameter int conv_cycles = 12,
  parameter int width = 8
) (
  // clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // host pins and front-end sample
  input wire logic convert_start_n_in,
  input wire logic chip_select_n_in,
  input wire logic read_n_in,
  input wire logic [width-1:0] sample_in,
  // outputs
  input wire logic busy_out,
  input wire logic powered_out,
  input wire logic hold_out,
  input wire logic auto_power_down_out,
  input wire logic [width-1:0] result_bus_out,
  input wire logic result_bus_oe_out
);
  logic [15:0] busy_cnt_r;
  logic [15:0] pw_cnt_r;
  // pw count saturates so long powered spells never wrap
  // count only enabled cycles, the ones on which the design advances
  always_ff @(posedge ref_clk_in)
  begin
    if (clk_en_in)
    begin
      busy_cnt_r <= busy_out ? busy_cnt_r + 16'h0001 : 16'h0000;
      pw_cnt_r <= powered_out ? pw_cnt_r + {15'h0000, pw_cnt_r != 16'hffff}
        : 16'h0000;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in || !clk_en_in);
  AST_BUSY_LEN: assert property ($fell(busy_out) |->
    busy_cnt_r == conv_cycles) else $error("busy length wrong");
  AST_HOLD_BUSY: assert property (hold_out == busy_out)
    else $error("hold and busy differ");
  AST_WAKE_UP: assert property ($rose(convert_start_n_in) &&
    !busy_out |=> ##[0:1] powered_out) else $error("no power-up");
  AST_NO_CONV_DOWN: assert property ($rose(busy_out) |->
    $past(powered_out)) else $error("conversion while down");
  AST_WAKE_TIME: assert property ($rose(busy_out) |->
    pw_cnt_r >= wake_cycles - 1) else $error("wake pulse short");
  AST_GATED_FALL: assert property ($rose(busy_out) |->
    !$past(convert_start_n_in)) else $error("start while high");
  AST_MODE_SEL: assert property ($fell(busy_out) |->
    auto_power_down_out == !$past(convert_start_n_in))
    else $error("mode wrong");
  AST_AUTO_DOWN: assert property ($fell(busy_out) |->
    powered_out == $past(convert_start_n_in)) else $error("power wrong");
  AST_READ_ON: assert property (!chip_select_n_in && !read_n_in |=>
    result_bus_oe_out) else $error("bus not driven");
  AST_READ_OFF: assert property (chip_select_n_in || read_n_in |=>
    !result_bus_oe_out) else $error("bus driven");
endmodule : adc_seq_chk
bind adc_convert_power_sequencer adc_seq_chk #(.wake_cycles(wake_cycles),
  .conv_cycles(conv_cycles), .width(width)) chk_u (.ref_clk_in, .rst_in,
  .clk_en_in, .convert_start_n_in, .chip_select_n_in, .read_n_in,
  .sample_in, .busy_out, .powered_out, .hold_out, .auto_power_down_out,
  .result_bus_out, .result_bus_oe_out);

// [dv/adc_convert_power_sequencer_bench.sv]
// self-checking bench of the converter sequencer
`timescale 1ns/1ps
module adc_convert_power_sequencer_bench;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] sample = 8'h00;
  wire logic start_n;
  logic busy, powered, hold, auto_pd, oe;
  logic [7:0] bus;
  logic [7:0] exp_q[$];
  logic oe_seen = 1'b0;
  int failures = 0;
  int n_checks = 0;
  int i;
  always #4 ref_clk_in = ~ref_clk_in;
  host_model host_u (.ref_clk_in(ref_clk_in), .convert_start_n_out(start_n));
  adc_convert_power_sequencer #(.wake_cycles(4), .conv_cycles(12)) dut_u (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(clk_en),
    .convert_start_n_in(start_n), .chip_select_n_in(cs_n),
    .read_n_in(rd_n), .sample_in(sample), .busy_out(busy),
    .powered_out(powered), .hold_out(hold), .auto_power_down_out(auto_pd),
    .result_bus_out(bus), .result_bus_oe_out(oe));
  task automatic stop_test();
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 100)
    begin
      @(negedge ref_clk_in);
      k++;
    end
    if (k == 100)
    begin
      failures++;
      $display("[ERR] %0t busy wait timed out", $time);
      stop_test();
    end
  endtask : wait_busy
  task automatic read_result(input logic [7:0] e);
    exp_q.push_back(e);
    @(negedge ref_clk_in);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    rd_n = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    cs_n = 1'b1;
  endtask : read_result
  // ****************************************
  // result monitor
  // ****************************************
  always @(negedge ref_clk_in)
  begin
    if (oe === 1'b1 && !oe_seen)
    begin
      if (exp_q.size() == 0)
        check(8'h01, 8'h00);
      else
        check(bus, exp_q.pop_front());
    end
    oe_seen = (oe === 1'b1);
  end
  initial
  begin
    i = $urandom(91);
    repeat (12) @(negedge ref_clk_in);
    rst_in = 1'b0;
    check(powered, 1'b0);
    check(auto_pd, 1'b1);
    repeat (20) @(negedge ref_clk_in);
    check(busy, 1'b0);
    for (i = 0; i < 3; i++)
    begin
      sample = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      host_u.start_pulse(2);
      wait_busy(1'b1);
      wait_busy(1'b0);
      check(powered, 1'b0);
      check(auto_pd, 1'b1);
      read_result(sample);
      repeat (13) @(negedge ref_clk_in);
    end
    sample = 8'($urandom);
    host_u.start_pulse(8);
    wait_busy(1'b1);
    host_u.start_level(1'b1);
    wait_busy(1'b0);
    check(powered, 1'b1);
    check(auto_pd, 1'b0);
    read_result(sample);
    sample = 8'($urandom);
    repeat (13) @(negedge ref_clk_in);
    host_u.start_level(1'b0);
    repeat (2) @(negedge ref_clk_in);
    check(busy, 1'b1);
    // freeze mid-conversion for longer than a whole conversion
    clk_en = 1'b0;
    repeat (14) @(negedge ref_clk_in);
    check(busy, 1'b1);
    check(hold, 1'b1);
    clk_en = 1'b1;
    wait_busy(1'b0);
    check(powered, 1'b0);
    read_result(sample);
    repeat (4) @(negedge ref_clk_in);
    check(oe, 1'b0);
    stop_test();
  end
endmodule : adc_convert_power_sequencer_bench
